// ---- pkg/fcm_edge_if.sv ----
// edge events of the sampled test pins, passed from detector to controller
// assumes both ends share CORE_CLK
`timescale 1ns/1ns
interface fcm_edge_if;
  logic mode_level;
  logic mode_fall;
  logic mode_rise;
  logic test_fall;
  logic first_valid;

  modport src
  (
    output mode_level,
    output mode_fall,
    output mode_rise,
    output test_fall,
    output first_valid
  );
  modport dst
  (
    input mode_level,
    input mode_fall,
    input mode_rise,
    input test_fall,
    input first_valid
  );
endinterface : fcm_edge_if

// ---- pkg/fcm_pkg.sv ----
// fuse check mode control: shared constants and types
// assumes a single 25 MHz core clock and an active-low power-on reset
package fcm_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [1:0] RISE_CNT_RST = 2'h0;
  localparam logic [1:0] RISE_CNT_END = 2'h2;
  localparam logic PIN_IDLE_HIGH = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam int KEY_BITS = 256;

  typedef enum logic [3:0]
  {
    FCM_POWERUP = 4'h1,
    FCM_ARMED = 4'h2,
    FCM_ACTIVE = 4'h4,
    FCM_DONE = 4'h8
  } fcm_state_type;

  localparam fcm_state_type STATE_RST = FCM_POWERUP;
endpackage : fcm_pkg

// ---- src/fcm_ctrl.sv ----
// fuse check mode control for the test access port
// assumes RST_B is the power-on reset and pins are synchronous to CORE_CLK
//
// Function
// - check only on first access after power-up
// - first mode-select falling edge activates check
// - mode-select low at power-up activates check
// - second mode-select rising edge ends check
// - after ending, stay off until power-on reset
// - sense enabled only active and mode-select low
// - test-enable falling ends check, sense off
// - protection needs blown fuse and access key
`timescale 1ns/1ns
module fcm_ctrl
(
  input wire logic CORE_CLK, // core clock, 25 MHz
  input wire logic RST_B, // power-on reset, active low
  input wire logic TMODE_SEL, // test mode-select pin level
  input wire logic TEST_EN, // test-enable pin level
  input wire logic FUSE_BLOWN, // fuse sensed as blown
  input wire logic KEY_REQUIRED, // loader entry demands full access key
  output logic FUSE_SENSE_EN, // enable fuse sense path
  output logic CHECK_ACTIVE, // check mode active
  output logic CHECK_DONE, // check mode spent for this power cycle
  output logic PROTECT_OK // memory protection guaranteed
);
  import fcm_pkg::*;

  fcm_edge_if ev();

  fcm_edge_det u_edge
  (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .mode_pin(TMODE_SEL),
    .test_pin(TEST_EN),
    .ev(ev)
  );

  fcm_state_type state_r;
  fcm_state_type state_nxt;
  logic [1:0] rise_cnt_r;
  logic [1:0] rise_cnt_nxt;
  logic sense_r;
  logic sense_nxt;
  logic prot_r;
  logic prot_nxt;
  logic active_r;
  logic active_nxt;
  logic done_r;
  logic done_nxt;

  // one decode of the active state feeds both the flag and the sense gate
  function automatic logic check_on(input fcm_state_type st);
    check_on = (st == FCM_ACTIVE);
  endfunction : check_on

  function automatic logic check_spent(input fcm_state_type st);
    check_spent = (st == FCM_DONE);
  endfunction : check_spent

  // counter saturates so a late fourth rise cannot wrap it back to zero
  function automatic logic rise_limit(input logic [1:0] cnt);
    rise_limit = (cnt == RISE_CNT_END);
  endfunction : rise_limit

  function automatic logic [1:0] rise_step(input logic [1:0] cnt, input logic rise);
    rise_step = cnt;
    if (rise && !rise_limit(cnt))
    begin
      rise_step = cnt + 2'h1;
    end
  endfunction : rise_step

  // rising edges counted from power-up, not from activation
  always_comb
  begin
    rise_cnt_nxt = rise_step(rise_cnt_r, ev.mode_rise);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rise_cnt_r <= RISE_CNT_RST;
    end
    else
    begin
      rise_cnt_r <= rise_cnt_nxt;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FCM_POWERUP:
      begin
        // first sampled level stands in for the pin during power-up
        if (ev.first_valid && !ev.mode_level)
        begin
          state_nxt = FCM_ACTIVE;
        end
        else
        begin
          state_nxt = FCM_ARMED;
        end
      end
      FCM_ARMED:
      begin
        if (ev.test_fall)
        begin
          state_nxt = FCM_DONE;
        end
        else if (rise_limit(rise_cnt_nxt))
        begin
          state_nxt = FCM_DONE;
        end
        else if (ev.mode_fall)
        begin
          state_nxt = FCM_ACTIVE;
        end
      end
      FCM_ACTIVE:
      begin
        if (ev.test_fall)
        begin
          state_nxt = FCM_DONE;
        end
        else if (rise_limit(rise_cnt_nxt))
        begin
          state_nxt = FCM_DONE;
        end
      end
      FCM_DONE:
      begin
        state_nxt = FCM_DONE;
      end
      default:
      begin
        state_nxt = FCM_DONE;
      end
    endcase
  end

  always_comb
  begin
    active_nxt = check_on(state_nxt);
    done_nxt = check_spent(state_nxt);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_r <= STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      active_r <= FLAG_RST;
      done_r <= FLAG_RST;
    end
    else
    begin
      active_r <= active_nxt;
      done_r <= done_nxt;
    end
  end

  // sense follows the next state so it drops in the same edge as the flag
  always_comb
  begin
    // host keeps the pin high to avoid draw while the check is active
    sense_nxt = check_on(state_nxt) && !TMODE_SEL;
  end

  // no sense current may flow while power-up is still in reset
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sense_r <= FLAG_RST;
    end
    else
    begin
      sense_r <= sense_nxt;
    end
  end

  // protection is a plain level pair, independent of the check mode
  always_comb
  begin
    prot_nxt = FUSE_BLOWN && KEY_REQUIRED;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      prot_r <= FLAG_RST;
    end
    else
    begin
      prot_r <= prot_nxt;
    end
  end

  assign FUSE_SENSE_EN = sense_r;
  assign CHECK_ACTIVE = active_r;
  assign CHECK_DONE = done_r;
  assign PROTECT_OK = prot_r;
endmodule : fcm_ctrl

// ---- src/fcm_edge_det.sv ----
// edge detector for the mode-select and test-enable pins
// assumes pins already synchronous to CORE_CLK
`timescale 1ns/1ns
module fcm_edge_det
(
  input wire logic clk, // core clock
  input wire logic rst_b, // power-on reset, active low
  input wire logic mode_pin, // mode-select level
  input wire logic test_pin, // test-enable level
  fcm_edge_if.src ev // edge events
);
  import fcm_pkg::*;

  logic mode_prev_r;
  logic mode_prev_nxt;
  logic test_prev_r;
  logic test_prev_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb
  begin
    mode_prev_nxt = mode_pin;
    test_prev_nxt = test_pin;
    seen_nxt = 1'b1;
  end

  // previous mode level resets to idle-high and test level to low, so no edge is faked at release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_prev_r <= PIN_IDLE_HIGH;
      test_prev_r <= FLAG_RST;
      seen_r <= FLAG_RST;
    end
    else
    begin
      mode_prev_r <= mode_prev_nxt;
      test_prev_r <= test_prev_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign ev.mode_level = mode_pin;
  assign ev.mode_fall = seen_r & mode_prev_r & ~mode_pin;
  assign ev.mode_rise = seen_r & ~mode_prev_r & mode_pin;
  assign ev.test_fall = seen_r & test_prev_r & ~test_pin;
  assign ev.first_valid = ~seen_r;
endmodule : fcm_edge_det

// ---- verif/fcm_ctrl_properties.sv ----
// fuse check control assertions
// assumes pins move at falling edges
`timescale 1ns/1ns
module fcm_ctrl_properties
(
  input logic CORE_CLK, // clk
  input logic RST_B, // rst
  input logic TMODE_SEL, // pin
  input logic TEST_EN, // pin
  input logic FUSE_BLOWN, // in
  input logic KEY_REQUIRED, // in
  input logic FUSE_SENSE_EN, // out
  input logic CHECK_ACTIVE, // out
  input logic CHECK_DONE, // out
  input logic PROTECT_OK // out
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  // first edge after reset only primes the pin samples
  sequence s_arm;
    $past(RST_B) && !CHECK_ACTIVE && !CHECK_DONE;
  endsequence
  chk_fall_entry: assert property (s_arm ##0 ($fell(TMODE_SEL) && TEST_EN) |=> CHECK_ACTIVE)
    else $error("no entry on fall");
  chk_low_boot: assert property ($rose(RST_B) && !TMODE_SEL |=> CHECK_ACTIVE && FUSE_SENSE_EN)
    else $error("no entry at boot");
  chk_high_boot: assert property ($rose(RST_B) && TMODE_SEL |=> !CHECK_ACTIVE && !CHECK_DONE)
    else $error("not armed at boot");
  chk_done_hold: assert property (CHECK_DONE |=> CHECK_DONE)
    else $error("done dropped");
  chk_done_quiet: assert property (CHECK_DONE |-> !CHECK_ACTIVE && !FUSE_SENSE_EN)
    else $error("active after done");
  chk_sense_gate: assert property (FUSE_SENSE_EN == (CHECK_ACTIVE && !$past(TMODE_SEL)))
    else $error("sense gate wrong");
  chk_test_end: assert property ($past(RST_B) && $fell(TEST_EN) |=> CHECK_DONE && !CHECK_ACTIVE)
    else $error("test end ignored");
  chk_protect_flag: assert property ($past(RST_B) |-> PROTECT_OK == $past(FUSE_BLOWN && KEY_REQUIRED))
    else $error("protect flag wrong");
endmodule : fcm_ctrl_properties
bind fcm_ctrl fcm_ctrl_properties u_chk
(
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .TMODE_SEL(TMODE_SEL), .TEST_EN(TEST_EN),
  .FUSE_BLOWN(FUSE_BLOWN), .KEY_REQUIRED(KEY_REQUIRED), .FUSE_SENSE_EN(FUSE_SENSE_EN),
  .CHECK_ACTIVE(CHECK_ACTIVE), .CHECK_DONE(CHECK_DONE), .PROTECT_OK(PROTECT_OK)
);

// ---- verif/fcm_host.sv ----
// test pin host model
// assumes requests settle before falling edges
`timescale 1ns/1ns
module fcm_host
(
  input logic clk, // clk
  input logic lo, // mode low request
  input logic en, // test enable request
  output logic tms, // pin
  output logic ten // pin
);
  initial
  begin
    {tms, ten} = 2'h2;
    forever @(negedge clk) {tms, ten} <= {!lo, en};
  end
endmodule : fcm_host

// ---- verif/tb_top.sv ----
// bench for fuse check control
// assumes host model owns the pins
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_b, lo, en, fb, kr, tms, ten;
  logic [3:0] o;
  int err_total, n_tests;
  fcm_host host (.clk(clk), .lo(lo), .en(en), .tms(tms), .ten(ten));
  fcm_ctrl dut (.CORE_CLK(clk), .RST_B(rst_b), .TMODE_SEL(tms), .TEST_EN(ten),
    .FUSE_BLOWN(fb), .KEY_REQUIRED(kr), .FUSE_SENSE_EN(o[3]),
    .CHECK_ACTIVE(o[2]), .CHECK_DONE(o[1]), .PROTECT_OK(o[0]));
  initial
  begin
    clk = 1'b0;
    forever #(fcm_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end
  task chk(input logic [3:0] e);
    n_tests++;
    err_total += int'(o !== e);
    if (o !== e)
      $display("CHECK FAILED %0t %h %h", $time, o, e);
  endtask : chk
  // v is {mode low, test enable, expected outputs}
  task pin(input logic [5:0] v);
    @(posedge clk);
    {lo, en} = v[5:4];
    @(posedge clk);
    #1 chk(v[3:0]);
  endtask : pin
  task por(input logic l);
    {lo, en} = {l, 1'b1};
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : por
  task walk;
    por(1'b0);
    pin(6'h3c);
    pin(6'h14);
    pin(6'h3c);
    pin(6'h12);
    pin(6'h32);
  endtask : walk
  task boot_low;
    por(1'b1);
    chk(4'hc);
    pin(6'h14);
    pin(6'h3c);
    pin(6'h12);
  endtask : boot_low
  task test_end;
    por(1'b0);
    pin(6'h02);
    pin(6'h32);
    por(1'b0);
    pin(6'h3c);
    pin(6'h22);
    pin(6'h12);
    pin(6'h32);
  endtask : test_end
  task protect;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      {fb, kr} = i[1:0];
      repeat (2) @(posedge clk);
      #1 chk({3'h1, i == 3});
    end
  endtask : protect
  task final_report;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    {rst_b, lo, en, fb, kr} = 5'h0;
    err_total = 0;
    n_tests = 0;
    walk();
    boot_low();
    test_end();
    protect();
    final_report();
  end
endmodule : tb_top
